//--- ident_regs_pkg.sv
// Constants for the identification and manufacturer-information command bank
package ident_regs_pkg;
  localparam logic [7:0] CMD_MAKER_REV    = 8'h9b;
  localparam logic [7:0] CMD_SERIAL       = 8'h9e;
  localparam logic [7:0] CMD_CHIP_ID      = 8'had;
  localparam logic [7:0] CMD_CHIP_REV     = 8'hae;
  localparam logic [7:0] CMD_LOOP_TUNING  = 8'hb1;
  localparam logic [7:0] CMD_STORE_ALL    = 8'h15;
  localparam logic [7:0] CMD_RESTORE_ALL  = 8'h16;
  localparam logic [7:0] CMD_NONE         = 8'h00;

  localparam logic [2:0] LEN_MAKER_REV    = 3'h3;
  localparam logic [2:0] LEN_SERIAL       = 3'h3;
  localparam logic [2:0] LEN_CHIP_ID      = 3'h6;
  localparam logic [2:0] LEN_CHIP_REV     = 3'h2;
  localparam logic [2:0] LEN_LOOP_TUNING  = 3'h5;

  localparam int IVC_BIT = 7;
  localparam int CML_STATUS_BYTE_BIT = 1;

  // Identification words are arbitrary neutral values
  localparam logic [47:0] CHIP_ID_VALUE   = 48'h5a_a5_01_02_03_04;
  localparam logic [3:0]  REV_FIRST       = 4'h1;
  localparam logic [3:0]  REV_SECOND      = 4'h0;
  localparam logic [7:0]  REV_THIRD       = 8'h00;

  // NVM image word indices
  localparam logic [1:0] NVM_IDX_MAKER    = 2'h0;
  localparam logic [1:0] NVM_IDX_SERIAL   = 2'h1;
  localparam logic [1:0] NVM_IDX_TUNING   = 2'h2;
  localparam logic [1:0] NVM_IDX_LAST     = 2'h2;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_RUN  = 2'b01,
    LD_DONE = 2'b11
  } load_state_e;
endpackage : ident_regs_pkg

//--- nvm_port_if.sv
// Interface between the command bank and its NVM image store
`timescale 1ns/10ps
`default_nettype none
interface nvm_port_if;
  logic        wrEn;
  logic [1:0]  addr;
  logic [39:0] wrData;
  logic [39:0] rdData;
  modport master (output wrEn, output addr, output wrData, input rdData);
  modport store  (input wrEn, input addr, input wrData, output rdData);
endinterface : nvm_port_if
`default_nettype wire

//--- nvm_image_store.sv
// Small NVM image memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module nvm_image_store (
  input  wire logic core_clk,
  nvm_port_if.store nvm
);
  logic [39:0] mem [0:3];
  logic [39:0] rdData_r;

  always_ff @(posedge core_clk) begin
    if (nvm.wrEn) begin
      mem[nvm.addr] <= nvm.wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    rdData_r <= mem[nvm.addr];
  end

  assign nvm.rdData = rdData_r;
endmodule : nvm_image_store
`default_nettype wire

//--- pmbus_identity_info_registers.sv
// Identification and manufacturer-information PMBus command bank
`timescale 1ns/10ps
`default_nettype none
module pmbus_identity_info_registers (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        cmdValid,
  input  wire logic        cmdWrite,
  input  wire logic [7:0]  cmdCode,
  input  wire logic [47:0] cmdWrData,
  input  wire logic [2:0]  cmdWrLen,
  input  wire logic        conversionOn,
  input  wire logic        useStrap,
  input  wire logic [39:0] strapTuning,
  input  wire logic        clearFaults,
  output logic             rdValid,
  output logic [47:0]      rdData,
  output logic [2:0]       rdLen,
  output logic             cmdError,
  output logic [39:0]      tuningHw,
  output logic [39:0]      tuningStored,
  output logic [23:0]      makerRevisionText,
  output logic [23:0]      unitSerialNumber,
  output logic [7:0]       statusByte,
  output logic [7:0]       statusCml,
  output logic             alertN,
  output logic [15:0]      nvmIntegritySum,
  output logic             loadDone
);
  import ident_regs_pkg::*;

  nvm_port_if nvm ();
  nvm_image_store uStore (
    .core_clk (core_clk),
    .nvm      (nvm)
  );

  function automatic logic isReadOnly(input logic [7:0] code);
    isReadOnly = (code == CMD_CHIP_ID) || (code == CMD_CHIP_REV);
  endfunction : isReadOnly

  function automatic logic [2:0] cmdLength(input logic [7:0] code);
    if (code == CMD_MAKER_REV) cmdLength = LEN_MAKER_REV;
    else if (code == CMD_SERIAL) cmdLength = LEN_SERIAL;
    else if (code == CMD_CHIP_ID) cmdLength = LEN_CHIP_ID;
    else if (code == CMD_CHIP_REV) cmdLength = LEN_CHIP_REV;
    else if (code == CMD_LOOP_TUNING) cmdLength = LEN_LOOP_TUNING;
    else cmdLength = 3'h0;
  endfunction : cmdLength

  load_state_e ldState_r;
  logic [1:0]  ldIdx_r;
  logic        ldCapture_r;
  logic [1:0]  ldCapIdx_r;
  logic        restoreReq;
  logic        storeReq;
  logic        wrOk;
  logic        wrBad;
  logic [1:0]  stIdx_r;
  logic        storing_r;
  logic [15:0] revWord;
  logic [47:0] idWord;

  assign revWord = {REV_FIRST, REV_SECOND, REV_THIRD};
  assign idWord  = CHIP_ID_VALUE;

  assign restoreReq = cmdValid && cmdWrite && (cmdCode == CMD_RESTORE_ALL);
  assign storeReq   = cmdValid && cmdWrite && (cmdCode == CMD_STORE_ALL);
  // Writes of a wrong byte count to writable codes are dropped silently; no fault is flagged
  assign wrOk  = cmdValid && cmdWrite && !isReadOnly(cmdCode) &&
                 (cmdLength(cmdCode) != 3'h0) && (cmdWrLen == cmdLength(cmdCode));
  assign wrBad = cmdValid && cmdWrite && isReadOnly(cmdCode);

  // Power-up and restore loader walks the NVM image
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ldState_r   <= LD_RUN;
      ldIdx_r     <= NVM_IDX_MAKER;
      ldCapture_r <= 1'b0;
      ldCapIdx_r  <= NVM_IDX_MAKER;
    end else begin
      ldCapture_r <= 1'b0;
      case (ldState_r)
        LD_IDLE: begin
          if (restoreReq && !storing_r) begin
            ldState_r <= LD_RUN;
            ldIdx_r   <= NVM_IDX_MAKER;
          end
        end
        LD_RUN: begin
          ldCapture_r <= 1'b1;
          ldCapIdx_r  <= ldIdx_r;
          if (ldIdx_r == NVM_IDX_LAST) begin
            ldState_r <= LD_DONE;
          end else begin
            ldIdx_r <= ldIdx_r + 2'h1;
          end
        end
        LD_DONE: begin
          ldState_r <= LD_IDLE;
        end
        default: ldState_r <= LD_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      loadDone <= 1'b0;
    end else if (ldState_r == LD_RUN) begin
      loadDone <= 1'b0;
    end else if (ldState_r == LD_DONE) begin
      loadDone <= 1'b1;
    end
  end

  // Store walks the three words out; loader and store never overlap
  always_ff @(posedge core_clk) begin
    if (srst) begin
      storing_r <= 1'b0;
      stIdx_r   <= NVM_IDX_MAKER;
    end else if (storing_r) begin
      if (stIdx_r == NVM_IDX_LAST) begin
        storing_r <= 1'b0;
      end
      stIdx_r <= stIdx_r + 2'h1;
    end else if (storeReq && ldState_r == LD_IDLE) begin
      storing_r <= 1'b1;
      stIdx_r   <= NVM_IDX_MAKER;
    end
  end

  always_comb begin
    nvm.wrEn   = storing_r;
    nvm.addr   = storing_r ? stIdx_r : ldIdx_r;
    nvm.wrData = 40'h0;
    if (stIdx_r == NVM_IDX_MAKER) begin
      nvm.wrData = {16'h0, makerRevisionText};
    end else if (stIdx_r == NVM_IDX_SERIAL) begin
      nvm.wrData = {16'h0, unitSerialNumber};
    end else begin
      nvm.wrData = tuningStored;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      makerRevisionText <= 24'h0;
    end else if (ldCapture_r && ldCapIdx_r == NVM_IDX_MAKER) begin
      makerRevisionText <= nvm.rdData[23:0];
    end else if (wrOk && cmdCode == CMD_MAKER_REV) begin
      makerRevisionText <= cmdWrData[23:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      unitSerialNumber <= 24'h0;
    end else if (ldCapture_r && ldCapIdx_r == NVM_IDX_SERIAL) begin
      unitSerialNumber <= nvm.rdData[23:0];
    end else if (wrOk && cmdCode == CMD_SERIAL) begin
      unitSerialNumber <= cmdWrData[23:0];
    end
  end

  // Stored tuning accepts writes whatever conversionOn is; hardware copy follows only when idle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tuningStored <= 40'h0;
    end else if (ldCapture_r && ldCapIdx_r == NVM_IDX_TUNING) begin
      tuningStored <= useStrap ? strapTuning : nvm.rdData;
    end else if (wrOk && cmdCode == CMD_LOOP_TUNING) begin
      tuningStored <= cmdWrData[39:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tuningHw <= 40'h0;
    end else if (ldCapture_r && ldCapIdx_r == NVM_IDX_TUNING) begin
      tuningHw <= useStrap ? strapTuning : nvm.rdData;
    end else if (wrOk && cmdCode == CMD_LOOP_TUNING && !conversionOn) begin
      tuningHw <= cmdWrData[39:0];
    end
  end

  // Simple add-only sum over maker text, serial and stored tuning, serial included
  always_ff @(posedge core_clk) begin
    if (srst) begin
      nvmIntegritySum <= 16'h0;
    end else begin
      nvmIntegritySum <= makerRevisionText[15:0] + {8'h0, makerRevisionText[23:16]} +
                         unitSerialNumber[15:0] + {8'h0, unitSerialNumber[23:16]} +
                         tuningStored[15:0] + tuningStored[31:16] +
                         {8'h0, tuningStored[39:32]};
    end
  end

  // Block read answer one cycle after the request
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdValid <= 1'b0;
      rdData  <= 48'h0;
      rdLen   <= 3'h0;
    end else begin
      rdValid <= cmdValid && !cmdWrite && (cmdLength(cmdCode) != 3'h0);
      rdLen   <= cmdLength(cmdCode);
      if (cmdCode == CMD_MAKER_REV) begin
        rdData <= {24'h0, makerRevisionText};
      end else if (cmdCode == CMD_SERIAL) begin
        rdData <= {24'h0, unitSerialNumber};
      end else if (cmdCode == CMD_CHIP_ID) begin
        rdData <= idWord;
      end else if (cmdCode == CMD_CHIP_REV) begin
        rdData <= {32'h0, revWord};
      end else if (cmdCode == CMD_LOOP_TUNING) begin
        rdData <= {8'h0, tuningStored};
      end else begin
        rdData <= 48'h0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmdError <= 1'b0;
    end else begin
      cmdError <= wrBad;
    end
  end

  // Fault set wins over a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      statusCml  <= 8'h0;
      statusByte <= 8'h0;
    end else if (wrBad) begin
      statusCml[IVC_BIT]              <= 1'b1;
      statusByte[CML_STATUS_BYTE_BIT] <= 1'b1;
    end else if (clearFaults) begin
      statusCml  <= 8'h0;
      statusByte <= 8'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      alertN <= 1'b1;
    end else if (wrBad) begin
      alertN <= 1'b0;
    end else if (clearFaults) begin
      alertN <= 1'b1;
    end
  end
endmodule : pmbus_identity_info_registers
`default_nettype wire

//--- pmbus_identity_info_registers_properties.sv
// Concurrent checks on the identity command bank ports
`timescale 1ns/10ps
`default_nettype none
module pmbus_identity_info_registers_properties
  import ident_regs_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        cmdValid,
  input wire logic        cmdWrite,
  input wire logic [7:0]  cmdCode,
  input wire logic [47:0] cmdWrData,
  input wire logic [2:0]  cmdWrLen,
  input wire logic        conversionOn,
  input wire logic        clearFaults,
  input wire logic        rdValid,
  input wire logic [47:0] rdData,
  input wire logic [2:0]  rdLen,
  input wire logic        cmdError,
  input wire logic [39:0] tuningHw,
  input wire logic [39:0] tuningStored,
  input wire logic [23:0] makerRevisionText,
  input wire logic [23:0] unitSerialNumber,
  input wire logic [7:0]  statusByte,
  input wire logic [7:0]  statusCml,
  input wire logic        alertN,
  input wire logic        loadDone
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [47:0] dataQ;
  logic        wr;
  assign wr = cmdValid && cmdWrite && loadDone;
  always_ff @(posedge core_clk) begin
    dataQ <= cmdWrData;
  end
  sequence s_rom_write;
    cmdValid && cmdWrite && (cmdCode == CMD_CHIP_ID || cmdCode == CMD_CHIP_REV);
  endsequence
  sequence s_fault_shown;
    cmdError && statusCml[IVC_BIT] && statusByte[CML_STATUS_BYTE_BIT] && !alertN;
  endsequence
  a_rom_write_flag: assert property (s_rom_write |=> s_fault_shown)
    else $error("read-only write not flagged");
  a_alert_held: assert property (!alertN && !clearFaults |=> !alertN)
    else $error("alert dropped early");
  a_alert_release: assert property (clearFaults && !cmdValid |=> alertN)
    else $error("alert not released");
  a_id_bytes: assert property (cmdValid && !cmdWrite && cmdCode == CMD_CHIP_ID
    |=> rdValid && rdLen == LEN_CHIP_ID && rdData == CHIP_ID_VALUE) else $error("bad identity read");
  a_rev_fields: assert property (cmdValid && !cmdWrite && cmdCode == CMD_CHIP_REV
    |=> rdValid && rdLen == LEN_CHIP_REV && rdData[15:0] == {REV_FIRST, REV_SECOND, REV_THIRD})
    else $error("bad revision read");
  a_serial_store: assert property (wr && cmdCode == CMD_SERIAL && cmdWrLen == LEN_SERIAL
    |=> unitSerialNumber == dataQ[23:0]) else $error("serial not stored");
  a_maker_store: assert property (wr && cmdCode == CMD_MAKER_REV && cmdWrLen == LEN_MAKER_REV
    |=> makerRevisionText == dataQ[23:0]) else $error("maker text not stored");
  a_tuning_live: assert property (wr && cmdCode == CMD_LOOP_TUNING && cmdWrLen == LEN_LOOP_TUNING
    && !conversionOn |=> tuningHw == dataQ[39:0] && tuningStored == dataQ[39:0]) else $error("tuning not applied");
  a_tuning_held: assert property (wr && cmdCode == CMD_LOOP_TUNING && cmdWrLen == LEN_LOOP_TUNING
    && conversionOn |=> tuningStored == dataQ[39:0] && $stable(tuningHw)) else $error("tuning not blocked");
endmodule : pmbus_identity_info_registers_properties
bind pmbus_identity_info_registers pmbus_identity_info_registers_properties i_props (.core_clk, .srst,
  .cmdValid, .cmdWrite, .cmdCode, .cmdWrData, .cmdWrLen, .conversionOn, .clearFaults, .rdValid, .rdData,
  .rdLen, .cmdError, .tuningHw, .tuningStored, .makerRevisionText, .unitSerialNumber, .statusByte,
  .statusCml, .alertN, .loadDone);
`default_nettype wire

//--- pmbus_host_model.sv
// Host-side command source for the identity bank
`timescale 1ns/10ps
`default_nettype none
module pmbus_host_model (
  input  wire logic   core_clk,
  output logic        cmdValid,
  output logic        cmdWrite,
  output logic [7:0]  cmdCode,
  output logic [47:0] cmdWrData,
  output logic [2:0]  cmdWrLen,
  output logic        clearFaults
);
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    cmdWrData = 48'h0;
    cmdWrLen = 3'h0;
    clearFaults = 1'b0;
  end
  // Payload inverted after release so stale data never looks valid
  task automatic xfer(input logic w, input logic [7:0] c, input logic [47:0] d, input logic [2:0] n);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdWrite <= w;
    cmdCode <= c;
    cmdWrData <= d;
    cmdWrLen <= n;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    cmdWrData <= ~d;
    #1;
  endtask : xfer
  task automatic clear();
    @(posedge core_clk);
    clearFaults <= 1'b1;
    @(posedge core_clk);
    clearFaults <= 1'b0;
    #1;
  endtask : clear
endmodule : pmbus_host_model
`default_nettype wire

//--- pmbus_identity_info_registers_tb.sv
// Self-checking bench for the identity command bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module pmbus_identity_info_registers_tb;
  import ident_regs_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, conversionOn = 1'b0, useStrap = 1'b0;
  logic [39:0] strapTuning = 40'h0;
  logic cmdValid, cmdWrite, clearFaults, rdValid, cmdError, alertN, loadDone;
  logic [7:0] cmdCode, statusByte, statusCml;
  logic [47:0] cmdWrData, rdData;
  logic [2:0] cmdWrLen, rdLen;
  logic [39:0] tuningHw, tuningStored;
  logic [23:0] makerRevisionText, unitSerialNumber;
  logic [15:0] nvmIntegritySum, sum0;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  always #20 core_clk = ~core_clk;
  pmbus_host_model i_host (.core_clk, .cmdValid, .cmdWrite, .cmdCode, .cmdWrData, .cmdWrLen, .clearFaults);
  pmbus_identity_info_registers i_dut (.core_clk, .srst, .cmdValid, .cmdWrite, .cmdCode, .cmdWrData,
    .cmdWrLen, .conversionOn, .useStrap, .strapTuning, .clearFaults, .rdValid, .rdData, .rdLen, .cmdError,
    .tuningHw, .tuningStored, .makerRevisionText, .unitSerialNumber, .statusByte, .statusCml, .alertN,
    .nvmIntegritySum, .loadDone);
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic rd(input logic [7:0] c, input logic [47:0] e, input logic [2:0] n);
    i_host.xfer(1'b0, c, 48'h0, 3'h0);
    `CHK(rdValid, 1'b1)
    `CHK(rdData, e)
    `CHK(rdLen, n)
  endtask : rd
  task automatic t_rw_stores();
    i_host.xfer(1'b1, CMD_MAKER_REV, 48'h00_a1b2c3, LEN_MAKER_REV);
    rd(CMD_MAKER_REV, 48'ha1b2c3, 3'h3);
    `CHK(makerRevisionText, 24'ha1b2c3)
    i_host.xfer(1'b1, CMD_SERIAL, 48'h123456, LEN_SERIAL);
    rd(CMD_SERIAL, 48'h123456, 3'h3);
    i_host.xfer(1'b1, CMD_SERIAL, 48'h0fffff, 3'h2);
    `CHK(unitSerialNumber, 24'h123456)
    i_host.xfer(1'b1, CMD_LOOP_TUNING, 48'h12_3456_789a, LEN_LOOP_TUNING);
    `CHK(tuningHw, 40'h12_3456_789a)
    rd(CMD_LOOP_TUNING, 48'h12_3456_789a, 3'h5);
    // Image starts unknown; every summed word is written before the sum is taken
    repeat (3) @(posedge core_clk);
    #1;
    sum0 = nvmIntegritySum;
    i_host.xfer(1'b1, CMD_SERIAL, 48'h654321, LEN_SERIAL);
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(nvmIntegritySum !== sum0, 1'b1)
  endtask : t_rw_stores
  task automatic t_rom();
    rd(CMD_CHIP_ID, CHIP_ID_VALUE, 3'h6);
    rd(CMD_CHIP_REV, {32'h0, REV_FIRST, REV_SECOND, REV_THIRD}, 3'h2);
    for (int k = 0; k < 2; k++) begin
      i_host.xfer(1'b1, k ? CMD_CHIP_REV : CMD_CHIP_ID, 48'h0, k ? LEN_CHIP_REV : LEN_CHIP_ID);
      `CHK({cmdError, statusCml[7], statusByte[1]}, 3'b111)
      `CHK(alertN, 1'b0)
      i_host.clear();
      `CHK(alertN, 1'b1)
    end
    rd(CMD_CHIP_ID, CHIP_ID_VALUE, 3'h6);
  endtask : t_rom
  task automatic t_tuning_blocked();
    @(posedge core_clk) conversionOn <= 1'b1;
    i_host.xfer(1'b1, CMD_LOOP_TUNING, 48'h55_aa00_ff11, LEN_LOOP_TUNING);
    `CHK({tuningStored, tuningHw}, {40'h55_aa00_ff11, 40'h12_3456_789a})
    // Host saves to NVM, then reloads to apply
    // Store and restore are write-direction commands with no payload
    i_host.xfer(1'b1, CMD_STORE_ALL, 48'h0, 3'h0);
    repeat (6) @(posedge core_clk);
    i_host.xfer(1'b1, CMD_RESTORE_ALL, 48'h0, 3'h0);
    repeat (10) @(posedge core_clk);
    #1;
    `CHK(tuningHw, 40'h55_aa00_ff11)
    @(posedge core_clk) useStrap <= 1'b1;
    strapTuning <= 40'h0f_0e0d_0c0b;
    i_host.xfer(1'b1, CMD_RESTORE_ALL, 48'h0, 3'h0);
    repeat (10) @(posedge core_clk);
    #1;
    `CHK(tuningHw, 40'h0f_0e0d_0c0b)
  endtask : t_tuning_blocked
  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 50 && loadDone !== 1'b1; i++) @(posedge core_clk);
    `CHK(loadDone, 1'b1)
    t_rw_stores();
    t_rom();
    t_tuning_blocked();
    print_verdict();
  end
endmodule : pmbus_identity_info_registers_tb
`default_nettype wire
